// ### armix_top.sv
// Two-path audio router: crosspoints, rate alignment, downmix, flex buses, clean switch
`timescale 1ns/1ps
module armix_top #(
  parameter int SAMPLE_W = armix_pkg::SAMPLE_W,
  parameter int PRES_HOLD = armix_pkg::PRES_HOLD
) (
  input wire logic ref_clk_in,
  input wire logic nrst_in,
  input wire logic [7:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  output logic irq_out,
  input wire logic sample_stb_in,
  input wire logic [1:0] switch_line_in,
  input wire logic [1:0] failover_req_in,
  input wire logic [3:0] failover_src_in,
  output logic [3:0] sdi_sel_out,
  input wire logic [16*SAMPLE_W-1:0] emb_p0_in,
  input wire logic [16*SAMPLE_W-1:0] emb_p1_in,
  input wire logic [16*SAMPLE_W-1:0] aes_in,
  input wire logic [7:0] aes_valid_in,
  input wire logic [7:0] aes_nonpcm_in,
  input wire logic [4*SAMPLE_W-1:0] ana_in,
  output logic [16*SAMPLE_W-1:0] emb_p0_out,
  output logic [16*SAMPLE_W-1:0] emb_p1_out,
  output logic [16*SAMPLE_W-1:0] aes_out,
  output logic [4*SAMPLE_W-1:0] ana_out
);
  import armix_pkg::*;
  localparam int W = SAMPLE_W;
  typedef logic signed [W-1:0] armix_smp_t;

  ////////////////////////////////////////////////////////////////////////////////
  // Reset release and bus slave
  logic [1:0] rst_sync_r;
  logic rst_n;
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rst_sync_r <= 2'b00;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_r[1];

  logic ack_r;
  logic [31:0] rd_mux;
  logic [31:0] be_mask;
  logic [31:0] wval;
  logic wr_en;
  assign avs_waitrequest_out = (avs_read_in | avs_write_in) & ~ack_r;
  assign wr_en = avs_write_in & ack_r;
  assign be_mask = {{8{avs_byteenable_in[3]}}, {8{avs_byteenable_in[2]}},
                    {8{avs_byteenable_in[1]}}, {8{avs_byteenable_in[0]}}};
  assign wval = (rd_mux & ~be_mask) | (avs_writedata_in & be_mask);
  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      ack_r <= 1'b0;
      avs_readdata_out <= 32'h0;
    end else begin
      ack_r <= (avs_read_in | avs_write_in) & ~ack_r;
      if (avs_read_in && !ack_r) begin
        avs_readdata_out <= rd_mux;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Configuration registers
  logic [1:0] clean_en_r;
  logic [SEL_W-1:0] ixp_r [2][N_CH];
  logic [SEL_W-1:0] exp_r [2][N_CH];
  logic [SEL_W-1:0] aes_sel_r [N_CH];
  logic [SEL_W-1:0] ana_sel_r [N_ANA];
  logic [35:0] flex_mask_r [N_FLEX];
  logic [31:0] oflex_mask_r;
  logic [GAIN_W-1:0] dmx_cg_r;
  logic [GAIN_W-1:0] dmx_sg_r;
  logic [19:0] dmx_sel_r;
  logic [SEL_W-1:0] peak_sel_r;
  logic peak_clr;
  logic [IRQ_W-1:0] irq_mask_r;
  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      clean_en_r <= 2'b00;
      oflex_mask_r <= 32'h0;
      dmx_cg_r <= DMX_GAIN_RST;
      dmx_sg_r <= DMX_GAIN_RST;
      dmx_sel_r <= DMX_SEL_RST;
      peak_sel_r <= '0;
      irq_mask_r <= '0;
      for (int i = 0; i < N_CH; i++) begin
        ixp_r[0][i] <= SEL_W'(i);
        ixp_r[1][i] <= SEL_W'(i);
        exp_r[0][i] <= SEL_W'(i);
        exp_r[1][i] <= SEL_W'(i);
        aes_sel_r[i] <= SEL_W'(i);
        flex_mask_r[i] <= '0;
      end
      for (int i = 0; i < N_ANA; i++) begin
        ana_sel_r[i] <= SEL_W'(i);
      end
    end else if (wr_en) begin
      if (avs_address_in == REG_CTRL) clean_en_r <= wval[1:0];
      if (avs_address_in == REG_IRQ_MASK) irq_mask_r <= wval[IRQ_W-1:0];
      if (avs_address_in == REG_OFLEX_MASK) oflex_mask_r <= wval;
      if (avs_address_in == REG_PEAK_SEL) peak_sel_r <= wval[SEL_W-1:0];
      if (avs_address_in == REG_DMX_SEL) dmx_sel_r <= wval[19:0];
      if (avs_address_in == REG_DMX_GAIN) begin
        dmx_cg_r <= wval[7:0];
        dmx_sg_r <= wval[15:8];
      end
      for (int i = 0; i < N_CH; i++) begin
        if (avs_address_in == REG_IXP0 + 8'(i)) ixp_r[0][i] <= wval[SEL_W-1:0];
        if (avs_address_in == REG_IXP1 + 8'(i)) ixp_r[1][i] <= wval[SEL_W-1:0];
        if (avs_address_in == REG_EXP0 + 8'(i)) exp_r[0][i] <= wval[SEL_W-1:0];
        if (avs_address_in == REG_EXP1 + 8'(i)) exp_r[1][i] <= wval[SEL_W-1:0];
        if (avs_address_in == REG_AES_OUT + 8'(i)) aes_sel_r[i] <= wval[SEL_W-1:0];
        if (avs_address_in == REG_FLEX_LO + 8'(i)) flex_mask_r[i][31:0] <= wval;
        if (avs_address_in == REG_FLEX_HI + 8'(i)) flex_mask_r[i][35:32] <= wval[3:0];
      end
      for (int i = 0; i < N_ANA; i++) begin
        if (avs_address_in == REG_ANA_OUT + 8'(i)) ana_sel_r[i] <= wval[SEL_W-1:0];
      end
    end
  end
  assign peak_clr = wr_en && (avs_address_in == REG_PEAK_VAL);

  ////////////////////////////////////////////////////////////////////////////////
  // Unpack inputs and AES rate alignment
  armix_smp_t emb_s [2][N_CH];
  armix_smp_t aes_s [N_CH];
  armix_smp_t ana_s [N_ANA];
  armix_smp_t aes_hold_r [N_CH];
  armix_smp_t aes_al [N_CH];
  logic [7:0] nonpcm_r;
  always_comb begin
    for (int i = 0; i < N_CH; i++) begin
      emb_s[0][i] = emb_p0_in[i*W +: W];
      emb_s[1][i] = emb_p1_in[i*W +: W];
      aes_s[i] = aes_in[i*W +: W];
      aes_al[i] = nonpcm_r[i/2] ? aes_s[i] : aes_hold_r[i];
    end
    for (int i = 0; i < N_ANA; i++) begin
      ana_s[i] = ana_in[i*W +: W];
    end
  end
  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      nonpcm_r <= 8'h0;
      for (int i = 0; i < N_CH; i++) aes_hold_r[i] <= '0;
    end else begin
      nonpcm_r <= aes_nonpcm_in;
      for (int i = 0; i < N_CH; i++) begin
        if (aes_valid_in[i/2]) aes_hold_r[i] <= aes_s[i];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Clean ducked switching per path
  armix_sw_state_t sw_st_r [2];
  logic [DUCK_W-1:0] gain_r [2];
  logic [1:0] sel_r [2];
  logic [1:0] pend_r [2];
  logic sw_done [2];
  logic cmd_stb [2];
  assign cmd_stb[0] = wr_en && avs_address_in == REG_SWITCH && !wval[SW_PATH_BIT];
  assign cmd_stb[1] = wr_en && avs_address_in == REG_SWITCH && wval[SW_PATH_BIT];
  for (genvar p = 0; p < 2; p++) begin : g_sw
    always_ff @(posedge ref_clk_in or negedge rst_n) begin
      if (!rst_n) begin
        sw_st_r[p] <= ARMIX_IDLE;
        gain_r[p] <= DUCK_UNITY;
        sel_r[p] <= 2'b00;
        pend_r[p] <= 2'b00;
        sw_done[p] <= 1'b0;
      end else begin
        sw_done[p] <= 1'b0;
        if (failover_req_in[p]) begin
          sel_r[p] <= failover_src_in[2*p +: 2];
          gain_r[p] <= DUCK_UNITY;
          sw_st_r[p] <= ARMIX_IDLE;
        end else if (cmd_stb[p] && !clean_en_r[p]) begin
          sel_r[p] <= wval[SW_SRC_LSB +: SW_SRC_W];
          sw_done[p] <= 1'b1;
        end else if (cmd_stb[p]) begin
          pend_r[p] <= wval[SW_SRC_LSB +: SW_SRC_W];
          sw_st_r[p] <= ARMIX_FADE_OUT;
        end else begin
          unique case (sw_st_r[p])
            ARMIX_IDLE: begin
              gain_r[p] <= DUCK_UNITY;
            end
            ARMIX_FADE_OUT: begin
              if (sample_stb_in) begin
                if (gain_r[p] <= DUCK_STEP) begin
                  gain_r[p] <= '0;
                  sw_st_r[p] <= ARMIX_WAIT_LINE;
                end else begin
                  gain_r[p] <= gain_r[p] - DUCK_STEP;
                end
              end
            end
            ARMIX_WAIT_LINE: begin
              if (switch_line_in[p]) begin
                sel_r[p] <= pend_r[p];
                sw_st_r[p] <= ARMIX_FADE_IN;
              end
            end
            ARMIX_FADE_IN: begin
              if (sample_stb_in) begin
                if (gain_r[p] >= DUCK_UNITY - DUCK_STEP) begin
                  gain_r[p] <= DUCK_UNITY;
                  sw_st_r[p] <= ARMIX_IDLE;
                  sw_done[p] <= 1'b1;
                end else begin
                  gain_r[p] <= gain_r[p] + DUCK_STEP;
                end
              end
            end
          endcase
        end
      end
    end
  end
  assign sdi_sel_out = {sel_r[1], sel_r[0]};

  ////////////////////////////////////////////////////////////////////////////////
  // Ducking, flex nodes, downmix and input crosspoint
  armix_smp_t duck_s [2][N_CH];
  armix_smp_t flex_s [N_FLEX];
  armix_smp_t bus_r [2][N_CH];
  armix_smp_t dm_l;
  armix_smp_t dm_r;
  armix_smp_t oflex_s;
  always_comb begin
    logic signed [ACC_W-1:0] acc;
    logic signed [ACC_W-1:0] side;
    acc = '0;
    side = '0;
    for (int p = 0; p < 2; p++) begin
      for (int i = 0; i < N_CH; i++) begin
        acc = ACC_W'(emb_s[p][i]) * $signed({1'b0, gain_r[p]});
        duck_s[p][i] = armix_sat(acc >>> GAIN_W);
      end
    end
    for (int n = 0; n < N_FLEX; n++) begin
      acc = '0;
      for (int i = 0; i < N_CH; i++) begin
        if (flex_mask_r[n][i]) acc = acc + ACC_W'(aes_al[i]);
        if (flex_mask_r[n][20 + i]) acc = acc + ACC_W'(duck_s[0][i]);
      end
      for (int i = 0; i < N_ANA; i++) begin
        if (flex_mask_r[n][16 + i]) acc = acc + ACC_W'(ana_s[i]);
      end
      flex_s[n] = armix_sat(acc);
    end
    side = ACC_W'(duck_s[0][dmx_sel_r[8 +: 4]]) * $signed({1'b0, dmx_cg_r});
    acc = ACC_W'(duck_s[0][dmx_sel_r[0 +: 4]]) + (side >>> GAIN_W)
        + ((ACC_W'(duck_s[0][dmx_sel_r[12 +: 4]]) * $signed({1'b0, dmx_sg_r})) >>> GAIN_W);
    dm_l = armix_sat(acc);
    acc = ACC_W'(duck_s[0][dmx_sel_r[4 +: 4]]) + (side >>> GAIN_W)
        + ((ACC_W'(duck_s[0][dmx_sel_r[16 +: 4]]) * $signed({1'b0, dmx_sg_r})) >>> GAIN_W);
    dm_r = armix_sat(acc);
    acc = '0;
    for (int i = 0; i < N_CH; i++) begin
      if (oflex_mask_r[i]) acc = acc + ACC_W'(bus_r[0][i]);
      if (oflex_mask_r[16 + i]) acc = acc + ACC_W'(bus_r[1][i]);
    end
    oflex_s = armix_sat(acc);
  end

  function automatic armix_smp_t in_pick(input int p, input logic [SEL_W-1:0] s);
    if (s < SRC_AES) return duck_s[p][s[3:0]];
    if (s < SRC_ANA) return aes_al[s[3:0]];
    if (s < SRC_FLEX) return ana_s[s[1:0]];
    if (s < SRC_FLEX + 6'h10) return flex_s[4'(s - SRC_FLEX)];
    return '0;
  endfunction

  function automatic armix_smp_t disc_pick(input logic [SEL_W-1:0] s);
    if (s < DOUT_P1) return bus_r[0][s[3:0]];
    if (s < DOUT_DML) return bus_r[1][s[3:0]];
    if (s == DOUT_DML) return dm_l;
    if (s == DOUT_DMR) return dm_r;
    if (s == DOUT_OFLEX) return oflex_s;
    return '0;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Internal buses and output crosspoints, advanced on each sample tick
  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      for (int p = 0; p < 2; p++) begin
        for (int i = 0; i < N_CH; i++) bus_r[p][i] <= '0;
      end
    end else if (sample_stb_in) begin
      for (int p = 0; p < 2; p++) begin
        for (int i = 0; i < N_CH; i++) bus_r[p][i] <= in_pick(p, ixp_r[p][i]);
      end
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      emb_p0_out <= '0;
      emb_p1_out <= '0;
      aes_out <= '0;
      ana_out <= '0;
    end else if (sample_stb_in) begin
      for (int i = 0; i < N_CH; i++) begin
        for (int p = 0; p < 2; p++) begin
          armix_smp_t v;
          v = '0;
          if (exp_r[p][i] < EOUT_ALT) v = bus_r[p][exp_r[p][i][3:0]];
          else if (exp_r[p][i] < EOUT_DML) v = bus_r[1-p][exp_r[p][i][3:0]];
          else if (exp_r[p][i] == EOUT_DML) v = dm_l;
          else if (exp_r[p][i] == EOUT_DMR) v = dm_r;
          if (p == 0) emb_p0_out[i*W +: W] <= v;
          else emb_p1_out[i*W +: W] <= v;
        end
        aes_out[i*W +: W] <= disc_pick(aes_sel_r[i]);
      end
      for (int i = 0; i < N_ANA; i++) ana_out[i*W +: W] <= disc_pick(ana_sel_r[i]);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Input presence and peak metering
  armix_smp_t mon_s [N_MON];
  logic [W-1:0] peak_r [N_MON];
  logic [15:0] idle_cnt_r [N_MON];
  logic [N_MON-1:0] pres_r;
  logic [N_MON-1:0] pres_q_r;
  always_comb begin
    for (int i = 0; i < N_CH; i++) begin
      mon_s[i] = emb_s[0][i];
      mon_s[N_CH + i] = emb_s[1][i];
      mon_s[2*N_CH + i] = aes_al[i];
    end
    for (int i = 0; i < N_ANA; i++) mon_s[3*N_CH + i] = ana_s[i];
  end
  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      pres_r <= '0;
      pres_q_r <= '0;
      for (int i = 0; i < N_MON; i++) begin
        peak_r[i] <= '0;
        idle_cnt_r[i] <= '0;
      end
    end else begin
      pres_q_r <= pres_r;
      for (int i = 0; i < N_MON; i++) begin
        logic [W-1:0] mag;
        mag = mon_s[i][W-1] ? W'(-mon_s[i]) : W'(mon_s[i]);
        if (peak_clr) begin
          peak_r[i] <= '0;
        end else if (sample_stb_in && mag > peak_r[i]) begin
          peak_r[i] <= mag;
        end
        if (sample_stb_in) begin
          if (mag != '0) begin
            idle_cnt_r[i] <= '0;
            pres_r[i] <= 1'b1;
          end else if (idle_cnt_r[i] >= 16'(PRES_HOLD - 1)) begin
            pres_r[i] <= 1'b0;
          end else begin
            idle_cnt_r[i] <= idle_cnt_r[i] + 16'h1;
          end
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Interrupt status, set wins over write-one-to-clear
  logic [IRQ_W-1:0] irq_stat_r;
  logic [IRQ_W-1:0] irq_set;
  logic [7:0] nonpcm_q_r;
  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      nonpcm_q_r <= 8'h0;
    end else begin
      nonpcm_q_r <= nonpcm_r;
    end
  end
  always_comb begin
    irq_set = '0;
    irq_set[IRQ_SW0] = sw_done[0];
    irq_set[IRQ_SW1] = sw_done[1];
    irq_set[IRQ_NONPCM] = |(nonpcm_r ^ nonpcm_q_r);
    irq_set[IRQ_LOSS] = |(pres_q_r & ~pres_r);
  end
  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      irq_stat_r <= '0;
    end else if (wr_en && avs_address_in == REG_IRQ_STAT) begin
      irq_stat_r <= (irq_stat_r & ~wval[IRQ_W-1:0]) | irq_set;
    end else begin
      irq_stat_r <= irq_stat_r | irq_set;
    end
  end
  assign irq_out = |(irq_stat_r & irq_mask_r);

  ////////////////////////////////////////////////////////////////////////////////
  // Read mux
  always_comb begin
    rd_mux = 32'h0;
    unique case (avs_address_in)
      REG_CTRL: rd_mux = {30'h0, clean_en_r};
      REG_SWITCH: rd_mux = {24'h0, 2'b00, sw_st_r[1] == ARMIX_IDLE, sw_st_r[0] == ARMIX_IDLE,
                            sel_r[1], sel_r[0]};
      REG_IRQ_STAT: rd_mux = {28'h0, irq_stat_r};
      REG_IRQ_MASK: rd_mux = {28'h0, irq_mask_r};
      REG_NONPCM: rd_mux = {24'h0, nonpcm_r};
      REG_PRES_LO: rd_mux = pres_r[31:0];
      REG_PRES_HI: rd_mux = {12'h0, pres_r[N_MON-1:32]};
      REG_DMX_GAIN: rd_mux = {16'h0, dmx_sg_r, dmx_cg_r};
      REG_DMX_SEL: rd_mux = {12'h0, dmx_sel_r};
      REG_PEAK_SEL: rd_mux = {26'h0, peak_sel_r};
      REG_PEAK_VAL: rd_mux = (peak_sel_r < SEL_W'(N_MON)) ? 32'(peak_r[peak_sel_r]) : 32'h0;
      REG_OFLEX_MASK: rd_mux = oflex_mask_r;
      default: begin
        for (int i = 0; i < N_CH; i++) begin
          if (avs_address_in == REG_IXP0 + 8'(i)) rd_mux = 32'(ixp_r[0][i]);
          if (avs_address_in == REG_IXP1 + 8'(i)) rd_mux = 32'(ixp_r[1][i]);
          if (avs_address_in == REG_EXP0 + 8'(i)) rd_mux = 32'(exp_r[0][i]);
          if (avs_address_in == REG_EXP1 + 8'(i)) rd_mux = 32'(exp_r[1][i]);
          if (avs_address_in == REG_AES_OUT + 8'(i)) rd_mux = 32'(aes_sel_r[i]);
          if (avs_address_in == REG_FLEX_LO + 8'(i)) rd_mux = flex_mask_r[i][31:0];
          if (avs_address_in == REG_FLEX_HI + 8'(i)) rd_mux = 32'(flex_mask_r[i][35:32]);
        end
        for (int i = 0; i < N_ANA; i++) begin
          if (avs_address_in == REG_ANA_OUT + 8'(i)) rd_mux = 32'(ana_sel_r[i]);
        end
      end
    endcase
  end
endmodule

// ### armix_pkg.sv
// Constants, register map and types of the audio routing mixer
package armix_pkg;
  localparam int SAMPLE_W = 24;
  localparam int ACC_W = 40;
  localparam int N_CH = 16;
  localparam int N_AES_PAIR = 8;
  localparam int N_ANA = 4;
  localparam int N_FLEX = 16;
  localparam int N_MON = 52;
  localparam int SEL_W = 6;
  // Input crosspoint source codes
  localparam logic [5:0] SRC_EMB = 6'h00;
  localparam logic [5:0] SRC_AES = 6'h10;
  localparam logic [5:0] SRC_ANA = 6'h20;
  localparam logic [5:0] SRC_FLEX = 6'h24;
  // Embedded output source codes
  localparam logic [5:0] EOUT_ALT = 6'h10;
  localparam logic [5:0] EOUT_DML = 6'h20;
  localparam logic [5:0] EOUT_DMR = 6'h21;
  // Discrete output source codes
  localparam logic [5:0] DOUT_P1 = 6'h10;
  localparam logic [5:0] DOUT_DML = 6'h20;
  localparam logic [5:0] DOUT_DMR = 6'h21;
  localparam logic [5:0] DOUT_OFLEX = 6'h22;
  // Register word indexes
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_SWITCH = 8'h01;
  localparam logic [7:0] REG_IRQ_STAT = 8'h02;
  localparam logic [7:0] REG_IRQ_MASK = 8'h03;
  localparam logic [7:0] REG_NONPCM = 8'h04;
  localparam logic [7:0] REG_PRES_LO = 8'h05;
  localparam logic [7:0] REG_PRES_HI = 8'h06;
  localparam logic [7:0] REG_DMX_GAIN = 8'h07;
  localparam logic [7:0] REG_DMX_SEL = 8'h08;
  localparam logic [7:0] REG_PEAK_SEL = 8'h09;
  localparam logic [7:0] REG_PEAK_VAL = 8'h0A;
  localparam logic [7:0] REG_OFLEX_MASK = 8'h0B;
  localparam logic [7:0] REG_IXP0 = 8'h10;
  localparam logic [7:0] REG_IXP1 = 8'h20;
  localparam logic [7:0] REG_EXP0 = 8'h30;
  localparam logic [7:0] REG_EXP1 = 8'h40;
  localparam logic [7:0] REG_AES_OUT = 8'h50;
  localparam logic [7:0] REG_ANA_OUT = 8'h60;
  localparam logic [7:0] REG_FLEX_LO = 8'h70;
  localparam logic [7:0] REG_FLEX_HI = 8'h80;
  // Field positions, widths, gain constants, reset values and presence hold
  localparam int SW_PATH_BIT = 8;
  localparam int SW_SRC_LSB = 0;
  localparam int SW_SRC_W = 2;
  localparam int GAIN_W = 8;
  localparam int DUCK_W = 9;
  localparam logic [8:0] DUCK_UNITY = 9'h100;
  localparam logic [8:0] DUCK_STEP = 9'h008;
  localparam logic [7:0] DMX_GAIN_RST = 8'hB5;
  localparam logic [19:0] DMX_SEL_RST = 20'h43210;
  localparam int PRES_HOLD = 4800;
  // Interrupt bits
  localparam int IRQ_SW0 = 0;
  localparam int IRQ_SW1 = 1;
  localparam int IRQ_NONPCM = 2;
  localparam int IRQ_LOSS = 3;
  localparam int IRQ_W = 4;
  typedef enum logic [3:0] {
    ARMIX_IDLE = 4'b0001,
    ARMIX_FADE_OUT = 4'b0010,
    ARMIX_WAIT_LINE = 4'b0100,
    ARMIX_FADE_IN = 4'b1000
  } armix_sw_state_t;
  function automatic logic signed [SAMPLE_W-1:0] armix_sat(input logic signed [ACC_W-1:0] a);
    logic signed [ACC_W-1:0] hi;
    logic signed [ACC_W-1:0] lo;
    hi = ACC_W'((64'sd1 <<< (SAMPLE_W - 1)) - 64'sd1);
    lo = -hi - ACC_W'(1);
    if (a > hi) begin
      return hi[SAMPLE_W-1:0];
    end else if (a < lo) begin
      return lo[SAMPLE_W-1:0];
    end
    return a[SAMPLE_W-1:0];
  endfunction
endpackage

// ### armix_monitor.sv
// Port checks of the audio routing mixer
`timescale 1ns/1ps
module armix_monitor #(
  parameter int SAMPLE_W = 24,
  parameter int PRES_HOLD = 4800
) (
  input wire logic ref_clk_in,
  input wire logic nrst_in,
  input wire logic [7:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_readdata_out,
  input wire logic avs_waitrequest_out,
  input wire logic irq_out,
  input wire logic sample_stb_in,
  input wire logic [1:0] switch_line_in,
  input wire logic [1:0] failover_req_in,
  input wire logic [3:0] failover_src_in,
  input wire logic [3:0] sdi_sel_out,
  input wire logic [16*SAMPLE_W-1:0] emb_p0_out,
  input wire logic [16*SAMPLE_W-1:0] aes_out,
  input wire logic [4*SAMPLE_W-1:0] ana_out
);
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!nrst_in);
  chk_emb_hold: assert property (!sample_stb_in |=> $stable(emb_p0_out))
    else $error("embedded out moved off tick");
  chk_aes_hold: assert property (!sample_stb_in |=> $stable(aes_out))
    else $error("aes out moved off tick");
  chk_ana_hold: assert property (!sample_stb_in |=> $stable(ana_out))
    else $error("analog out moved off tick");
  chk_failover_sel: assert property (failover_req_in[0] |=>
    sdi_sel_out[1:0] == $past(failover_src_in[1:0])) else $error("failover select wrong");
  chk_sel_cause: assert property (!$stable(sdi_sel_out[1:0]) |->
    $past(failover_req_in[0] | switch_line_in[0] | avs_write_in, 1) |
    $past(switch_line_in[0], 2)) else $error("select moved without cause");
  chk_wait_ack: assert property ((avs_read_in || avs_write_in) && avs_waitrequest_out
    |=> !avs_waitrequest_out) else $error("no ack after one wait");
  chk_wait_idle: assert property (!avs_read_in && !avs_write_in |-> !avs_waitrequest_out)
    else $error("wait without request");
  chk_unmapped_zero: assert property (avs_read_in && !avs_waitrequest_out &&
    avs_address_in == 8'hFF |-> avs_readdata_out == 32'h0) else $error("unmapped read");
  cover property (failover_req_in[0]);
  cover property ($rose(irq_out));
  cover property (switch_line_in[0] && sdi_sel_out[1:0] == 2'h0);
endmodule
bind armix_top armix_monitor #(.SAMPLE_W(SAMPLE_W), .PRES_HOLD(PRES_HOLD)) i_armix_monitor (.*);

// ### armix_far_end.sv
// Far-side sources: embedded, AES and analog samples on a sample tick, and a video switch line
`timescale 1ns/1ps
module armix_far_end #(
  parameter int SAMPLE_W = armix_pkg::SAMPLE_W
) (
  input wire logic ref_clk_in,
  input wire logic [23:0] base_in,
  output logic sample_stb_out,
  output logic [1:0] switch_line_out,
  output logic [16*SAMPLE_W-1:0] emb_p0_out,
  output logic [16*SAMPLE_W-1:0] emb_p1_out,
  output logic [16*SAMPLE_W-1:0] aes_out,
  output logic [7:0] aes_valid_out,
  output logic [4*SAMPLE_W-1:0] ana_out
);
  import armix_pkg::*;
  logic [7:0] cnt_r = 8'h00;
  always_ff @(posedge ref_clk_in) begin
    cnt_r <= cnt_r + 8'h01;
  end
  // Sources steady, same rate, PCM only
  always_comb begin
    sample_stb_out = cnt_r[1:0] == 2'h3;
    switch_line_out = {2{cnt_r[5:0] == 6'h3B}};
    aes_valid_out = {8{sample_stb_out}};
    for (int i = 0; i < 16; i++) begin
      emb_p0_out[i*SAMPLE_W+:SAMPLE_W] = SAMPLE_W'(base_in + 24'(i));
      emb_p1_out[i*SAMPLE_W+:SAMPLE_W] = SAMPLE_W'(base_in + 24'(i) + 24'h000100);
      aes_out[i*SAMPLE_W+:SAMPLE_W] = SAMPLE_W'(base_in + 24'(i) + 24'h000200);
    end
    for (int i = 0; i < 4; i++) begin
      ana_out[i*SAMPLE_W+:SAMPLE_W] = SAMPLE_W'(base_in + 24'(i) + 24'h000300);
    end
  end
endmodule

// ### test_armix_top.sv
// Self-checking bench of the audio routing mixer
`timescale 1ns/1ps
module test_armix_top;
  import armix_pkg::*;
  typedef struct {logic [7:0] a; logic [31:0] d; logic [31:0] e;} armix_row_t;
  logic ref_clk = 1'b0, nrst = 1'b0, rd = 1'b0, wr = 1'b0, stb, waitreq, irq;
  logic [7:0] addr = 8'h00, aes_v;
  logic [31:0] wdata = 32'h0, rdata, q;
  logic [1:0] line, fo_req = 2'h0;
  logic [3:0] fo_src = 4'h0, sel;
  logic [383:0] emb0, emb1, aes, e0o, e1o, aeso;
  logic [95:0] ana, anao;
  logic [23:0] base = 24'h010000;
  logic [7:0] npcm = 8'h00;
  int bad_count = 0, tests_run = 0, n;
  armix_row_t rows[6];
  always #5 ref_clk = ~ref_clk;
  armix_top #(.PRES_HOLD(8)) i_armix_top (.ref_clk_in(ref_clk), .nrst_in(nrst),
    .avs_address_in(addr), .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdata),
    .avs_byteenable_in(4'hF), .avs_readdata_out(rdata), .avs_waitrequest_out(waitreq),
    .irq_out(irq), .sample_stb_in(stb), .switch_line_in(line), .failover_req_in(fo_req),
    .failover_src_in(fo_src), .sdi_sel_out(sel), .emb_p0_in(emb0), .emb_p1_in(emb1),
    .aes_in(aes), .aes_valid_in(aes_v), .aes_nonpcm_in(npcm), .ana_in(ana),
    .emb_p0_out(e0o), .emb_p1_out(e1o), .aes_out(aeso), .ana_out(anao));
  armix_far_end i_armix_far_end (.ref_clk_in(ref_clk), .base_in(base), .sample_stb_out(stb),
    .switch_line_out(line), .emb_p0_out(emb0), .emb_p1_out(emb1), .aes_out(aes),
    .aes_valid_out(aes_v), .ana_out(ana));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic stop_test;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  function automatic logic [31:0] ch(input logic [383:0] v, input int i);
    return {8'h00, v[i*24+:24]};
  endfunction
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    addr <= a;
    wr <= w;
    rd <= !w;
    wdata <= d;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (waitreq !== 1'b0 && n < 20);
    chk({31'h0, waitreq}, 32'h0);
    if (waitreq !== 1'b0) stop_test();
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    rows = '{'{REG_CTRL, 32'h3, 32'h3}, '{REG_IRQ_MASK, 32'hF, 32'hF},
      '{REG_PEAK_SEL, 32'h5, 32'h5}, '{REG_DMX_GAIN, 32'h4080, 32'h4080},
      '{REG_IXP1 + 8'h05, 32'h5, 32'h5}, '{8'hFF, 32'h1234, 32'h0}};
    repeat (6) @(posedge ref_clk);
    chk({28'h0, sel}, 32'h0);
    nrst <= 1'b1;
    repeat (3) @(posedge ref_clk);
    foreach (rows[i]) begin
      bus(1'b1, rows[i].a, rows[i].d);
      bus(1'b0, rows[i].a, 32'h0);
      chk(q, rows[i].e);
    end
    for (int i = 0; i < 16; i++) chk(ch(e0o, i), 32'(base) + 32'(i));
    for (int i = 0; i < 16; i++) chk(ch(e1o, i), 32'(base) + 32'(i) + 32'h100);
    bus(1'b1, REG_IXP0, 32'h10);
    bus(1'b1, REG_IXP0 + 8'h01, 32'h20);
    bus(1'b1, REG_EXP0 + 8'h03, 32'h13);
    bus(1'b1, REG_AES_OUT + 8'h04, 32'h14);
    bus(1'b1, REG_ANA_OUT + 8'h01, 32'h11);
    bus(1'b1, REG_EXP0 + 8'h05, 32'h20);
    bus(1'b1, REG_AES_OUT + 8'h06, 32'h21);
    bus(1'b1, REG_FLEX_LO, 32'h10001);
    bus(1'b1, REG_IXP0 + 8'h02, 32'h24);
    bus(1'b1, REG_OFLEX_MASK, 32'h20001);
    bus(1'b1, REG_ANA_OUT + 8'h02, 32'h22);
    repeat (16) @(posedge ref_clk);
    chk(ch(e0o, 0), 32'(base) + 32'h200);
    chk(ch(e0o, 1), 32'(base) + 32'h300);
    chk(ch(e0o, 3), 32'(base) + 32'h103);
    chk(ch(aeso, 0), 32'(base) + 32'h200);
    chk(ch(aeso, 4), 32'(base) + 32'h104);
    chk(ch(384'(anao), 1), 32'(base) + 32'h101);
    chk(ch(e0o, 5), 32'h1C001);
    chk(ch(aeso, 6), 32'h1C003);
    chk(ch(e0o, 2), 32'h20500);
    chk(ch(384'(anao), 2), 32'h20301);
    bus(1'b0, REG_PEAK_VAL, 32'h0);
    chk(q, 32'h10005);
    bus(1'b0, REG_PRES_LO, 32'h0);
    chk(q, 32'hFFFFFFFF);
    bus(1'b1, REG_IRQ_STAT, 32'hF);
    bus(1'b1, REG_IRQ_MASK, 32'h1);
    bus(1'b1, REG_SWITCH, 32'h2);
    chk({28'h0, sel}, 32'h0);
    n = 0;
    while (irq !== 1'b1 && n < 3000) begin
      @(negedge ref_clk);
      n++;
    end
    chk({31'h0, irq}, 32'h1);
    if (irq !== 1'b1) stop_test();
    chk({28'h0, sel}, 32'h2);
    bus(1'b1, REG_IRQ_STAT, 32'h1);
    @(negedge ref_clk);
    chk({31'h0, irq}, 32'h0);
    @(posedge ref_clk);
    fo_src <= 4'h9;
    fo_req <= 2'h3;
    @(posedge ref_clk);
    fo_req <= 2'h0;
    @(negedge ref_clk);
    chk({28'h0, sel}, 32'h9);
    bus(1'b1, REG_CTRL, 32'h1);
    npcm <= 8'h01;
    bus(1'b1, REG_SWITCH, 32'h103);
    @(negedge ref_clk);
    chk({28'h0, sel}, 32'hD);
    chk({31'h0, irq}, 32'h0);
    bus(1'b0, REG_IRQ_STAT, 32'h0);
    chk({31'h0, q[1]}, 32'h1);
    chk({31'h0, q[2]}, 32'h1);
    bus(1'b0, REG_NONPCM, 32'h0);
    chk(q, 32'h1);
    stop_test();
  end
endmodule
